// >>> src/card_dma_pkg.sv
/*
 Shared constants for the card DMA mask and cycle timing block.
 Assumes a single 200 MHz clock.
*/
package card_dma_pkg;
    // ==================================================
    // register map (byte offsets from DMA base)
    localparam logic [3:0] CLEAR_OFFSET = 4'hD;
    localparam logic [3:0] MASK_OFFSET = 4'hF;
    localparam logic [7:0] MASK_RESET = 8'h01;
    localparam int MASK_BIT = 0;
    localparam int CLEAR_LANE = 1;
    localparam int MASK_LANE = 3;
    // ==================================================
    // interval counts in card clocks
    localparam logic [7:0] SETUP_IO = 8'h03;
    localparam logic [7:0] SETUP_MEM_LO = 8'h02;
    localparam logic [7:0] SETUP_MEM_HI = 8'h04;
    localparam logic [7:0] HOLD_SHORT = 8'h02;
    localparam logic [7:0] HOLD_MEM_HI = 8'h03;
    localparam logic [7:0] ACT8_IO = 8'h13;
    localparam logic [7:0] ACT8_IO_WAIT = 8'h17;
    localparam logic [7:0] ACT8_IO_ZERO = 8'h07;
    localparam logic [7:0] ACT8_MEM0 = 8'h13;
    localparam logic [7:0] ACT8_MEM_WAIT = 8'h17;
    localparam logic [7:0] ACT16_IO = 8'h07;
    localparam logic [7:0] ACT16_IO_WAIT = 8'h0B;
    localparam logic [7:0] ACT16_MEM0 = 8'h09;
    localparam logic [7:0] ACT16_MEM1 = 8'h0D;
    localparam logic [7:0] ACT16_MEM2 = 8'h11;
    localparam logic [7:0] ACT16_MEM3 = 8'h17;
    localparam logic [7:0] ACT_MEM_ZERO = 8'h05;
    localparam logic [7:0] ACT8_MEM_ZERO = 8'h07;
    // ==================================================
    // card clock: 30 ns reference period, 5 ns system clock
    localparam int CARD_CLOCK_NS = 30;
    localparam int SYS_CLOCK_NS = 5;
    localparam int CARD_DIV = (CARD_CLOCK_NS + SYS_CLOCK_NS - 1)
        / SYS_CLOCK_NS;
    typedef enum logic [3:0] {
        IDLE_type_s = 4'h1,
        SETUP_type_s = 4'h2,
        ACTIVE_type_s = 4'h4,
        HOLD_type_s = 4'h8
    } phase_type;
endpackage

// >>> src/cycle_req_if.sv
/*
 Interface carrying one card cycle request and its phase back.
 Assumes both ends share mclk.
*/
`timescale 1ns/100ps
interface cycle_req_if;
    logic start;
    logic isIo;
    logic wide;
    logic ioWaitSelect;
    logic zeroWaitSelect;
    logic [1:0] memWait;
    logic busy;
    logic cmdActive;
    logic addrValid;
    modport master(output start, isIo, wide, ioWaitSelect,
        zeroWaitSelect, memWait, input busy, cmdActive, addrValid);
    modport gen(input start, isIo, wide, ioWaitSelect,
        zeroWaitSelect, memWait, output busy, cmdActive, addrValid);
endinterface

// >>> src/card_cycle_gen.sv
/*
 Card cycle generator: setup, command active and hold phases.
 Assumes a one-cycle card clock enable from the parent.
*/
`timescale 1ns/100ps
module card_cycle_gen
    import card_dma_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tick,
    // request
    cycle_req_if.gen req
);
    phase_type phase;
    logic [7:0] count;
    logic isIo, wide, ioWait, zeroWait;
    logic [1:0] memWait;

    // ==================================================
    // interval selection
    function automatic logic [7:0] setupLen(input logic io,
        input logic [1:0] mw);
        if (io) return SETUP_IO;
        return mw[1] ? SETUP_MEM_HI : SETUP_MEM_LO;
    endfunction

    function automatic logic [7:0] holdLen(input logic io,
        input logic [1:0] mw);
        if (io) return HOLD_SHORT;
        return mw[1] ? HOLD_MEM_HI : HOLD_SHORT;
    endfunction

    function automatic logic [7:0] activeLen(input logic io,
        input logic w, input logic ws, input logic zw,
        input logic [1:0] mw);
        if (io) begin
            if (ws) return w ? ACT16_IO_WAIT : ACT8_IO_WAIT;
            if (zw) return w ? ACT16_IO : ACT8_IO_ZERO;
            return w ? ACT16_IO : ACT8_IO;
        end
        // zero wait on memory is slower for byte-wide cycles
        if (mw == 2'h0 && zw) return w ? ACT_MEM_ZERO : ACT8_MEM_ZERO;
        if (!w) return (mw == 2'h0) ? ACT8_MEM0 : ACT8_MEM_WAIT;
        case (mw)
            2'h0: return ACT16_MEM0;
            2'h1: return ACT16_MEM1;
            2'h2: return ACT16_MEM2;
            default: return ACT16_MEM3;
        endcase
    endfunction

    // ==================================================
    // phase sequencer
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            phase <= IDLE_type_s;
            count <= 8'h00;
            isIo <= 1'b0;
            wide <= 1'b0;
            ioWait <= 1'b0;
            zeroWait <= 1'b0;
            memWait <= 2'h0;
        end else begin
            case (phase)
                IDLE_type_s: begin
                    if (req.start) begin
                        isIo <= req.isIo;
                        wide <= req.wide;
                        ioWait <= req.ioWaitSelect;
                        zeroWait <= req.zeroWaitSelect;
                        memWait <= req.memWait;
                        count <= setupLen(req.isIo, req.memWait);
                        phase <= SETUP_type_s;
                    end
                end
                SETUP_type_s: begin
                    if (tick) begin
                        if (count == 8'h01) begin
                            count <= activeLen(isIo, wide, ioWait,
                                zeroWait, memWait);
                            phase <= ACTIVE_type_s;
                        end else begin
                            count <= count - 8'h01;
                        end
                    end
                end
                ACTIVE_type_s: begin
                    if (tick) begin
                        if (count == 8'h01) begin
                            count <= holdLen(isIo, memWait);
                            phase <= HOLD_type_s;
                        end else begin
                            count <= count - 8'h01;
                        end
                    end
                end
                HOLD_type_s: begin
                    if (tick) begin
                        if (count == 8'h01) begin
                            count <= 8'h00;
                            phase <= IDLE_type_s;
                        end else begin
                            count <= count - 8'h01;
                        end
                    end
                end
                default: phase <= IDLE_type_s;
            endcase
        end
    end

    assign req.busy = (phase != IDLE_type_s);
    assign req.cmdActive = (phase == ACTIVE_type_s);
    assign req.addrValid = (phase != IDLE_type_s);
endmodule

// >>> src/card_dma_mask_and_cycle_timing.sv
/*
 Socket DMA channel clear and request mask, plus card cycle timing.
 Assumes register writes arrive as synchronous strobes with byte
 enables, and card status inputs synchronous to mclk.
*/
// Behaviour
// - Any write to the clear byte resets the whole DMA channel.
// - Only mask bit 0 exists; bits 7-1 read zero and ignore writes.
// - A set mask blocks card requests, clear lets them through; resets set.
// - Card removal sets the mask by itself.
// - Card-present flags also block the channel.
// - Cycle timing comes from the wait bits of the covering window.
// - Setup, active and hold are counted in card clocks.
// - Setup and hold depend on wait bits and on I/O versus memory.
// - Setup is 3 for I/O, 2 or 4 for memory by the upper wait bit.
// - 8-bit active is 19, 23 or 7 for I/O and 19 or 7 for memory code 0, 23 for codes 1-3.
// - 16-bit active is 7 or 11 for I/O and 9/13/17/23 or 5 for memory.
// - Hold is 2 except 3 for memory with the upper wait bit set.
`timescale 1ns/100ps
module card_dma_mask_and_cycle_timing
    import card_dma_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port (doubleword at base + 0Ch)
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] byteEnable,
    input wire logic [31:0] writeData,
    output logic [31:0] readData,
    // card status and request
    input wire logic cardPresent,
    input wire logic cardIs16Bit,
    input wire logic cardRemoved,
    input wire logic cardDmaRequest,
    output logic dmaRequestOut,
    output logic channelClear,
    // cycle request
    input wire logic cycleStart,
    input wire logic cycleIsIo,
    input wire logic cycleWide,
    input wire logic io_wait_select,
    input wire logic zero_wait_select,
    input wire logic [1:0] memory_wait_code,
    output logic cycleBusy,
    output logic cardCommand,
    output logic cardAddressValid
);
    logic maskBit;
    logic clearHit;
    logic chanRst_b;
    logic [2:0] divCount;
    logic tick;
    cycle_req_if req();

    // ==================================================
    // channel clear
    // the lane check is what lets neighbours be written safely
    assign clearHit = regWrite && byteEnable[CLEAR_LANE];
    assign chanRst_b = rst_b && !clearHit;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            channelClear <= 1'b0;
        end else begin
            channelClear <= clearHit;
        end
    end

    // ==================================================
    // request mask
    // removal wins over a mask write in the same cycle; a channel clear wins over both
    always_ff @(posedge mclk) begin
        if (!chanRst_b) begin
            maskBit <= MASK_RESET[MASK_BIT];
        end else if (cardRemoved) begin
            maskBit <= 1'b1;
        end else if (regWrite && byteEnable[MASK_LANE]) begin
            maskBit <= writeData[8 * MASK_LANE + MASK_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            readData <= 32'h0000_0000;
        end else if (regRead) begin
            readData <= {7'h00, maskBit, 24'h00_0000};
        end
    end

    always_ff @(posedge mclk) begin
        if (!chanRst_b) begin
            dmaRequestOut <= 1'b0;
        end else begin
            dmaRequestOut <= cardDmaRequest && !maskBit
                && cardPresent && cardIs16Bit;
        end
    end

    // ==================================================
    // card clock enable divider
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            divCount <= 3'h0;
        end else if (divCount == 3'(CARD_DIV - 1)) begin
            divCount <= 3'h0;
        end else begin
            divCount <= divCount + 3'h1;
        end
    end
    assign tick = (divCount == 3'(CARD_DIV - 1));

    // ==================================================
    // cycle generator
    assign req.start = cycleStart;
    assign req.isIo = cycleIsIo;
    assign req.wide = cycleWide;
    assign req.ioWaitSelect = io_wait_select;
    assign req.zeroWaitSelect = zero_wait_select;
    assign req.memWait = memory_wait_code;

    card_cycle_gen cycleGen (
        .mclk(mclk),
        .rst_b(chanRst_b),
        .tick(tick),
        .req(req.gen)
    );

    assign cycleBusy = req.busy;
    assign cardCommand = req.cmdActive;
    assign cardAddressValid = req.addrValid;
endmodule

// >>> sim/card_dma_monitor.sv
/*
 Checker on the top ports of the card DMA mask and cycle timing block.
 Assumes it is bound to that module and that no clear hits a busy cycle.
*/
`timescale 1ns/100ps
module card_dma_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port and card
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] byteEnable,
    input wire logic [31:0] readData,
    input wire logic cardPresent,
    input wire logic cardIs16Bit,
    input wire logic cardRemoved,
    input wire logic cardDmaRequest,
    input wire logic dmaRequestOut,
    input wire logic channelClear,
    // cycle generator
    input wire logic cycleStart,
    input wire logic cycleBusy,
    input wire logic cardCommand,
    input wire logic cardAddressValid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==============================
    // channel and mask
    property p_clr; regWrite && byteEnable[1] |=> channelClear; endproperty
    a_clr: assert property (p_clr) else $error("clear missing");
    property p_clrm; regWrite && byteEnable[1] |=> !dmaRequestOut[*2];
    endproperty
    a_clrm: assert property (p_clrm) else $error("clear kept request");
    property p_rsv; regRead |=> readData[31:25] == 7'h00
        && readData[23:0] == 24'h000000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_gate; dmaRequestOut |->
        $past(cardDmaRequest && cardPresent && cardIs16Bit); endproperty
    a_gate: assert property (p_gate) else $error("ungated request");
    property p_rem; cardRemoved |-> ##2 !dmaRequestOut; endproperty
    a_rem: assert property (p_rem) else $error("removal not masked");
    // ==============================
    // cycle phases
    property p_cmd; cardCommand |-> cycleBusy && cardAddressValid;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command outside cycle");
    property p_go; cycleStart && !cycleBusy |=> cycleBusy; endproperty
    a_go: assert property (p_go) else $error("start not taken");
    property p_set; $rose(cycleBusy) |-> !cardCommand[*6]; endproperty
    a_set: assert property (p_set) else $error("setup too short");
    property p_act; $rose(cardCommand) |-> cardCommand[*8]; endproperty
    a_act: assert property (p_act) else $error("command too short");
    property p_hold; $fell(cardCommand) |-> cycleBusy[*8]; endproperty
    a_hold: assert property (p_hold) else $error("hold too short");
    property p_end; $rose(cycleBusy) |-> ##[1:200] !cycleBusy; endproperty
    a_end: assert property (p_end) else $error("cycle never ends");
endmodule
bind card_dma_mask_and_cycle_timing card_dma_monitor card_dma_monitor_inst (
    .mclk, .rst_b, .regWrite, .regRead, .byteEnable, .readData,
    .cardPresent, .cardIs16Bit, .cardRemoved, .cardDmaRequest,
    .dmaRequestOut, .channelClear, .cycleStart, .cycleBusy, .cardCommand,
    .cardAddressValid);

// >>> sim/card_model.sv
/*
 Card side model: presence, width, removal pulse and DMA request.
 Assumes the bench calls its tasks; it drives on the falling mclk edge.
*/
`timescale 1ns/100ps
module card_model (
    // clock
    input wire logic mclk,
    // card status
    output logic cardPresent = 1'h1,
    output logic cardIs16Bit = 1'h1,
    output logic cardRemoved = 1'h0,
    output logic cardDmaRequest = 1'h0
);
    // a pulled card also drops its request line
    task automatic pull();
        @(negedge mclk);
        cardPresent = 1'h0;
        cardRemoved = 1'h1;
        cardDmaRequest = 1'h0;
        @(negedge mclk);
        cardRemoved = 1'h0;
    endtask
    task automatic plug(input logic wide, input logic req);
        @(negedge mclk);
        cardPresent = 1'h1;
        cardIs16Bit = wide;
        cardDmaRequest = req;
    endtask
endmodule

// >>> sim/tb_top.sv
/*
 Self-checking bench for the card DMA mask and cycle timing block.
 Assumes the card model and the bound monitor are compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [5:0] ctl;
        logic [7:0] su;
        logic [7:0] act;
        logic [7:0] hd;
    } row_type;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [3:0] byteEnable = 4'h0;
    logic [31:0] writeData = 32'h0;
    logic cycleStart = 1'h0;
    // io, wide, io wait, zero wait, memory wait code
    logic [5:0] ctl = 6'h0;
    logic [31:0] readData;
    logic cardPresent, cardIs16Bit, cardRemoved, cardDmaRequest;
    logic dmaRequestOut, channelClear, cycleBusy, cardCommand;
    logic cardAddressValid;
    int failures = 0;
    int tests_run = 0;
    row_type rows [15] = '{'{6'h20, 8'h03, 8'h13, 8'h02},
        '{6'h28, 8'h03, 8'h17, 8'h02}, '{6'h24, 8'h03, 8'h07, 8'h02},
        '{6'h00, 8'h02, 8'h13, 8'h02}, '{6'h02, 8'h04, 8'h17, 8'h03},
        '{6'h30, 8'h03, 8'h07, 8'h02}, '{6'h38, 8'h03, 8'h0B, 8'h02},
        '{6'h10, 8'h02, 8'h09, 8'h02}, '{6'h11, 8'h02, 8'h0D, 8'h02},
        '{6'h12, 8'h04, 8'h11, 8'h03}, '{6'h13, 8'h04, 8'h17, 8'h03},
        '{6'h14, 8'h02, 8'h05, 8'h02}, '{6'h04, 8'h02, 8'h07, 8'h02},
        '{6'h01, 8'h02, 8'h17, 8'h02}, '{6'h34, 8'h03, 8'h07, 8'h02}};
    always #2.5 mclk = ~mclk;
    card_model card_model_inst (.mclk, .cardPresent, .cardIs16Bit,
        .cardRemoved, .cardDmaRequest);
    card_dma_mask_and_cycle_timing card_dma_mask_and_cycle_timing_inst (
        .mclk, .rst_b, .regWrite, .regRead, .byteEnable, .writeData,
        .readData, .cardPresent, .cardIs16Bit, .cardRemoved,
        .cardDmaRequest, .dmaRequestOut, .channelClear, .cycleStart,
        .cycleIsIo(ctl[5]), .cycleWide(ctl[4]), .io_wait_select(ctl[3]),
        .zero_wait_select(ctl[2]), .memory_wait_code(ctl[1:0]), .cycleBusy,
        .cardCommand, .cardAddressValid);
    // ==============================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        regWrite = 1'h1;
        byteEnable = be;
        writeData = d;
        @(negedge mclk);
        regWrite = 1'h0;
        byteEnable = 4'h0;
    endtask
    task automatic rd(input logic [31:0] exp);
        @(negedge mclk);
        regRead = 1'h1;
        @(negedge mclk);
        regRead = 1'h0;
        check(readData, exp);
    endtask
    task automatic req(input logic exp);
        repeat (3) @(negedge mclk);
        check(dmaRequestOut, exp);
    endtask
    // first phase may lose up to one card clock to tick alignment
    task automatic run(input row_type r);
        int s = 0;
        int a = 0;
        int h = 0;
        @(negedge mclk);
        ctl = r.ctl;
        cycleStart = 1'h1;
        @(negedge mclk);
        cycleStart = 1'h0;
        for (int i = 0; i < 300 && cycleBusy === 1'h1; i++) begin
            if (cardCommand === 1'h1) a++;
            else if (a == 0) s++;
            else h++;
            @(negedge mclk);
        end
        check(cycleBusy, 1'h0);
        check(cardAddressValid, 1'h0);
        check(s <= r.su * 6 && s + 6 > r.su * 6, 1'h1);
        check(a, r.act * 6);
        check(h, r.hd * 6);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==============================
    // main sequence
    initial begin
        repeat (6) @(negedge mclk);
        rst_b = 1'h1;
        foreach (rows[k]) run(rows[k]);
        rd(32'h0100_0000);
        wr(4'h8, 32'hFE00_0000);
        check(channelClear, 1'h0);
        rd(32'h0000_0000);
        wr(4'h8, 32'hFFFF_FFFF);
        rd(32'h0100_0000);
        card_model_inst.plug(1'h1, 1'h1);
        req(1'h0);
        wr(4'h8, 32'h0000_0000);
        req(1'h1);
        card_model_inst.plug(1'h0, 1'h1);
        req(1'h0);
        card_model_inst.pull();
        rd(32'h0100_0000);
        card_model_inst.plug(1'h1, 1'h1);
        req(1'h0);
        wr(4'h8, 32'h0000_0000);
        req(1'h1);
        wr(4'h2, 32'h0000_0000);
        check(channelClear, 1'h1);
        req(1'h0);
        rd(32'h0100_0000);
        // ==============================
        // reset in mid-cycle, held two edges
        wr(4'h8, 32'h0000_0000);
        @(negedge mclk);
        ctl = 6'h20;
        cycleStart = 1'h1;
        @(negedge mclk);
        cycleStart = 1'h0;
        check(cardAddressValid, 1'h1);
        rst_b = 1'h0;
        repeat (2) @(negedge mclk);
        rst_b = 1'h1;
        check(cycleBusy, 1'h0);
        check(readData, 32'h0000_0000);
        check(dmaRequestOut, 1'h0);
        rd(32'h0100_0000);
        run(rows[0]);
        print_verdict();
    end
endmodule
